// *** shared/tpf_pkg.sv ***
// shared constants and carrier types for the trigger packet fifo store
package tpf_pkg;
    localparam int WORD_W = 16;
    localparam int PKT_WORDS = 20;
    localparam int NUM_CH = 4;
    localparam int STORE_BYTES = 33554432;
    localparam int BYTES_PER_WORD = 2;
    localparam int STORE_WORDS_DFLT = STORE_BYTES / BYTES_PER_WORD;
    localparam int STORE_PKTS_DFLT = 800000;
    localparam int FIFO_DEPTH_DFLT = 16;
    localparam int EN_BIT_POS = 8;
    localparam logic [15:0] HDR_W0 = 16'h2211;
    localparam logic [15:0] HDR_W1 = 16'h4433;
    localparam logic [15:0] HDR_W2 = 16'h6655;
    localparam int HDR_WORDS = 3;
    localparam logic [4:0] LAST_IDX = 5'h13;
    localparam logic [3:0] PEND_RST = 4'h0;

    // one record word plus a flag marking the last word of the record
    typedef struct packed {
        logic [15:0] data;
        logic last;
    } tpf_word_t;

    // payload words 3..19 supplied by the capture logic
    typedef struct packed {
        logic [16:0][15:0] words;
    } tpf_payload_t;
endpackage

// *** hdl/tpf_fifo.sv ***
// parameterised valid/ready fifo
`timescale 1ns/1ns
module tpf_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // level
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [$clog2(DEPTH+1)-1:0] cnt_ff;
    logic push;
    logic pop;

    assign in_ready = (cnt_ff != DEPTH[$clog2(DEPTH+1)-1:0]);
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem[rd_ff];
    assign count = cnt_ff;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ff] <= in_data;
    end

    // pointers and level
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            if (push)
                wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
            if (pop)
                rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
            if (push && !pop)
                cnt_ff <= cnt_ff + 1'b1;
            else if (pop && !push)
                cnt_ff <= cnt_ff - 1'b1;
        end
    end

    a_fifo_no_over: assert property (@(posedge clk) disable iff (rst)
        cnt_ff <= DEPTH)
        else $error("fifo level above depth");
endmodule

// *** hdl/tpf_store.sv ***
// write-side control of the trigger packet fifo
`timescale 1ns/1ns
module tpf_store #(
    parameter int STORE_WORDS = tpf_pkg::STORE_WORDS_DFLT,
    parameter int FIFO_DEPTH = tpf_pkg::FIFO_DEPTH_DFLT
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control from the register side
    input wire logic [15:0] ctrl_word,
    input wire logic status_wr,
    input wire logic flush,
    // channel trigger pulses and captured payload
    input wire logic [3:0] ch_trig,
    input wire tpf_pkg::tpf_payload_t payload,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output tpf_pkg::tpf_word_t out_word,
    // status
    output logic [3:0] pend_ff,
    output logic [3:0] trig_gate_ff,
    output logic empty_ff,
    output logic full_ff,
    output logic drop_ff
);
    typedef enum logic [0:0] {ST_IDLE, ST_WRITE} tpf_state_t;
    localparam int CW = $clog2(STORE_WORDS + 1);
    localparam logic [CW-1:0] PKT_W = CW'(tpf_pkg::PKT_WORDS);

    tpf_state_t state_ff;
    logic [4:0] idx_ff;
    tpf_pkg::tpf_payload_t pay_ff;
    logic [CW-1:0] used_ff;
    logic en;
    logic [3:0] new_trig;
    logic start;
    logic [15:0] cur_data;
    logic f_in_ready;
    logic f_out_valid;
    logic wr_word;
    logic rd_word;
    tpf_pkg::tpf_word_t f_out;

    assign en = ctrl_word[tpf_pkg::EN_BIT_POS];
    assign new_trig = ch_trig & ~pend_ff;
    // whole record fits or nothing starts
    assign start = (state_ff == ST_IDLE) && en && (|new_trig) && !flush
        && (used_ff <= CW'(STORE_WORDS) - PKT_W);
    assign wr_word = (state_ff == ST_WRITE) && f_in_ready;
    // a word leaves the store when the host takes it from the output
    assign rd_word = out_valid && out_ready;

    // select header or payload word by index
    function automatic logic [15:0] pick(input logic [4:0] i,
        input tpf_pkg::tpf_payload_t p);
        logic [4:0] k;
        k = i - 5'(tpf_pkg::HDR_WORDS);
        case (i)
            5'h00: pick = tpf_pkg::HDR_W0;
            5'h01: pick = tpf_pkg::HDR_W1;
            5'h02: pick = tpf_pkg::HDR_W2;
            default: pick = p.words[k[4:0]];
        endcase
    endfunction

    assign cur_data = pick(idx_ff, pay_ff);

    // record sequencer
    always_ff @(posedge clk)
    begin
        if (rst || flush)
        begin
            state_ff <= ST_IDLE;
            idx_ff <= '0;
        end
        else
        begin
            unique case (state_ff)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        state_ff <= ST_WRITE;
                        idx_ff <= '0;
                    end
                end
                ST_WRITE:
                begin
                    if (wr_word)
                    begin
                        if (idx_ff == tpf_pkg::LAST_IDX)
                            state_ff <= ST_IDLE;
                        idx_ff <= idx_ff + 5'h01;
                    end
                end
            endcase
        end
    end

    // payload snapshot at trigger
    always_ff @(posedge clk)
    begin
        if (rst)
            pay_ff <= '0;
        else if (start)
            pay_ff <= payload;
    end

    // pending status: set by trigger, cleared by write or record end
    always_ff @(posedge clk)
    begin
        if (rst)
            pend_ff <= tpf_pkg::PEND_RST;
        else if (status_wr)
            pend_ff <= new_trig;
        else if (wr_word && idx_ff == tpf_pkg::LAST_IDX)
            pend_ff <= new_trig;
        else
            pend_ff <= pend_ff | ch_trig; // set wins over hold
    end

    // trigger pulse gated by pending status
    always_ff @(posedge clk)
    begin
        if (rst)
            trig_gate_ff <= '0;
        else
            trig_gate_ff <= new_trig;
    end

    // words reserved in the store, counted until drained
    always_ff @(posedge clk)
    begin
        if (rst || flush)
            used_ff <= '0;
        else
            used_ff <= used_ff + (start ? PKT_W : '0)
                - (rd_word ? CW'(1) : '0);
    end

    // status flags
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            empty_ff <= 1'b1;
            full_ff <= 1'b0;
            drop_ff <= 1'b0;
        end
        else
        begin
            empty_ff <= (used_ff == '0);
            full_ff <= (used_ff > CW'(STORE_WORDS) - PKT_W);
            drop_ff <= (state_ff == ST_IDLE) && en && (|new_trig)
                && !start;
        end
    end

    // output register stage
    always_ff @(posedge clk)
    begin
        if (rst || flush)
        begin
            out_valid <= 1'b0;
            out_word <= '0;
        end
        else if (!out_valid || out_ready)
        begin
            out_valid <= f_out_valid;
            out_word <= f_out;
        end
    end

    tpf_fifo #(
        .WIDTH($bits(tpf_pkg::tpf_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst || flush),
        .in_valid(state_ff == ST_WRITE),
        .in_ready(f_in_ready),
        .in_data({cur_data, idx_ff == tpf_pkg::LAST_IDX}),
        .out_valid(f_out_valid),
        .out_ready(!out_valid || out_ready),
        .out_data(f_out),
        .count()
    );

    a_disabled_no_start: assert property (@(posedge clk) disable iff (rst)
        !en |-> !start)
        else $error("record started while disabled");
    a_full_blocks: assert property (@(posedge clk) disable iff (rst)
        (used_ff > CW'(STORE_WORDS) - PKT_W) |-> !start)
        else $error("record started without room");
    a_header_first: assert property (@(posedge clk) disable iff (rst || flush)
        start |=> (cur_data == tpf_pkg::HDR_W0))
        else $error("record does not open with header");
    a_record_len: assert property (@(posedge clk) disable iff (rst || flush)
        wr_word && idx_ff == tpf_pkg::LAST_IDX |=> state_ff == ST_IDLE)
        else $error("record length wrong");
    a_pend_gate: assert property (@(posedge clk) disable iff (rst)
        (ch_trig & pend_ff) == ch_trig |-> !start)
        else $error("pending channel triggered");
    a_status_clr: assert property (@(posedge clk) disable iff (rst)
        status_wr && ch_trig == 4'h0 |=> pend_ff == 4'h0)
        else $error("status write did not clear");
    a_auto_clr: assert property (@(posedge clk) disable iff (rst)
        wr_word && idx_ff == tpf_pkg::LAST_IDX && !status_wr
        && ch_trig == 4'h0 |=> pend_ff == 4'h0)
        else $error("record end did not clear status");
    a_whole_record: assert property (@(posedge clk) disable iff (rst || flush)
        start |=> state_ff == ST_WRITE [*1] ##0 idx_ff == 5'h00)
        else $error("record did not begin at index zero");

    c_record: cover property (@(posedge clk) disable iff (rst)
        wr_word && idx_ff == tpf_pkg::LAST_IDX);
    c_drop: cover property (@(posedge clk) disable iff (rst) drop_ff);
    c_status_wr: cover property (@(posedge clk) disable iff (rst)
        status_wr && |pend_ff);
endmodule

// *** bench/tpf_host.sv ***
// host model draining stored records with optional stalls
`timescale 1ns/1ns
module tpf_host (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // drain side
    input wire logic out_valid,
    output logic out_ready,
    input wire tpf_pkg::tpf_word_t out_word,
    // pacing from the bench
    input wire logic stall,
    input wire logic slow
);
    tpf_pkg::tpf_word_t rx_q[$];
    logic ph = 1'b0;
    initial out_ready = 1'b0;
    // ready moves at the falling edge only; slow mode takes every other cycle
    always @(negedge clk)
    begin
        ph <= ~ph;
        out_ready <= ~stall & (~slow | ph);
    end
    // a word is taken at the rising edge where valid and ready meet
    always @(posedge clk)
    begin
        if (!rst && out_valid && out_ready)
        begin
            rx_q.push_back(out_word);
        end
    end
endmodule

// *** bench/tpf_store_tb_top.sv ***
// self-checking bench for the trigger packet fifo store
`timescale 1ns/1ns
module tpf_store_tb_top;
    localparam int STORE_W = 60; // room for three whole records
    typedef struct packed {
        logic [3:0] trig;
        logic en;
        logic [1:0] recs;
        logic [15:0] base;
    } tpf_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] ctrl_word = 16'h0000;
    logic status_wr = 1'b0;
    logic flush = 1'b0;
    logic [3:0] ch_trig = 4'h0;
    tpf_pkg::tpf_payload_t payload = '0;
    logic out_valid, out_ready, seen;
    logic stall = 1'b0;
    logic slow = 1'b0;
    tpf_pkg::tpf_word_t out_word;
    logic [3:0] pend_ff, trig_gate_ff;
    logic empty_ff, full_ff, drop_ff;
    int n_mismatch = 0;
    int checked = 0;
    int r, t;
    tpf_row_t rows[6] = '{'{4'h1, 1'h1, 2'h1, 16'h1000},
        '{4'h2, 1'h1, 2'h1, 16'h2000}, '{4'h4, 1'h1, 2'h1, 16'h3000},
        '{4'h8, 1'h1, 2'h1, 16'h4000}, '{4'h5, 1'h1, 2'h1, 16'h5000},
        '{4'hf, 1'h0, 2'h0, 16'h6000}};

    // fifo deep enough to hold every reserved word while the host stalls
    tpf_store #(.STORE_WORDS(STORE_W), .FIFO_DEPTH(64)) DUT (
        .clk(clk), .rst(rst), .ctrl_word(ctrl_word), .status_wr(status_wr),
        .flush(flush), .ch_trig(ch_trig), .payload(payload),
        .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word),
        .pend_ff(pend_ff), .trig_gate_ff(trig_gate_ff), .empty_ff(empty_ff),
        .full_ff(full_ff), .drop_ff(drop_ff));
    tpf_host host (
        .clk(clk), .rst(rst), .out_valid(out_valid), .out_ready(out_ready),
        .out_word(out_word), .stall(stall), .slow(slow));

    // 100 MHz clock
    always #5 clk = ~clk;

    // compare and count
    task automatic chk(input string name, input logic [31:0] seen_v, exp);
        checked++;
        if (seen_v !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen_v);
        end
    endtask

    // one-cycle trigger with a payload derived from base
    task automatic fire(input logic [3:0] m, input logic [15:0] b);
        int k;
        for (k = 0; k < 17; k++) payload.words[k] = b + 16'(k);
        ch_trig = m;
        @(negedge clk);
        ch_trig = 4'h0;
    endtask

    // one-cycle software status write
    task automatic stat_wr();
        status_wr = 1'b1;
        @(negedge clk);
        status_wr = 1'b0;
    endtask

    // wait for n words at the host, then a quiet span for stray words
    task automatic drain(input int n);
        int w;
        for (w = 0; w < 600 && host.rx_q.size() < n; w++) @(negedge clk);
        repeat (30) @(negedge clk);
        chk("count", 32'(host.rx_q.size()), 32'(n));
    endtask

    // pop one record and compare every word against headers and payload
    task automatic chk_rec(input logic [15:0] b);
        tpf_pkg::tpf_word_t w;
        logic [15:0] e;
        int i;
        if (host.rx_q.size() < 20) return;
        for (i = 0; i < 20; i++)
        begin
            w = host.rx_q.pop_front();
            e = i == 0 ? tpf_pkg::HDR_W0 : i == 1 ? tpf_pkg::HDR_W1 :
                i == 2 ? tpf_pkg::HDR_W2 : b + 16'(i - 3);
            chk("word", 32'(w.data), 32'(e));
            chk("last", 32'(w.last), 32'(i == 19));
        end
    endtask

    // verdict
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // watchdog
    initial
    begin
        #200000;
        n_mismatch++;
        complete_run();
    end

    // main sequence
    initial
    begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        chk("reset", 32'({pend_ff, out_valid, empty_ff, full_ff, drop_ff}),
            32'h4);
        ctrl_word = 16'h0100;
        stat_wr();
        foreach (rows[r])
        begin
            ctrl_word = 16'(rows[r].en) << tpf_pkg::EN_BIT_POS;
            @(negedge clk);
            fire(rows[r].trig, rows[r].base);
            drain(20 * rows[r].recs);
            if (rows[r].recs != 0)
            begin
                chk_rec(rows[r].base);
                chk("pend", 32'(pend_ff), 32'h0);
            end
            chk("empty", 32'(empty_ff), 32'h1);
        end
        ctrl_word = 16'h0100;
        stat_wr();
        // second trigger on a pending channel is held back
        fire(4'h1, 16'h7000);
        chk("gate", 32'(trig_gate_ff), 32'h1);
        fire(4'h1, 16'h7100);
        chk("gate", 32'(trig_gate_ff), 32'h0);
        chk("pend", 32'(pend_ff), 32'h1);
        stat_wr();
        chk("pend", 32'(pend_ff), 32'h0);
        drain(20);
        chk_rec(16'h7000);
        // fill the store with the host stalled, then overflow by one
        stall = 1'b1;
        for (r = 0; r < 3; r++)
        begin
            fire(4'h2, 16'h8000 + 16'(r * 256));
            repeat (30) @(negedge clk);
        end
        chk("full", 32'({empty_ff, full_ff}), 32'h1);
        seen = 1'b0;
        fire(4'h2, 16'h9000);
        for (t = 0; t < 3; t++)
        begin
            seen = seen | drop_ff;
            @(negedge clk);
        end
        chk("drop", 32'(seen), 32'h1);
        stat_wr();
        stall = 1'b0;
        slow = 1'b1;
        drain(60);
        for (r = 0; r < 3; r++) chk_rec(16'h8000 + 16'(r * 256));
        chk("flags", 32'({empty_ff, full_ff}), 32'h2);
        // a stored record is thrown away by a flush
        slow = 1'b0;
        stall = 1'b1;
        fire(4'h4, 16'ha000);
        repeat (25) @(negedge clk);
        flush = 1'b1;
        @(negedge clk);
        flush = 1'b0;
        stall = 1'b0;
        drain(0);
        chk("flush", 32'({out_valid, empty_ff, full_ff}), 32'h2);
        complete_run();
    end
endmodule
